// File: rtl/dip_pkg.sv
`default_nettype none
package dip_pkg;
   // Register byte offsets on the APB port
   localparam logic [7:0] ADDR_SRC_SEL = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_CNT0    = 8'h08;
   localparam logic [7:0] ADDR_CNT1    = 8'h0c;
   localparam logic [7:0] ADDR_CNT2    = 8'h10;
   localparam logic [7:0] ADDR_RANGE   = 8'h14;

   // Source select register fields
   localparam int SRC_FIRST_EN  = 0;
   localparam int SRC_SECOND_EN = 1;
   localparam int SRC_FIRST_HF  = 2;
   localparam logic [2:0] SRC_SEL_RST = 3'h0;

   // Status register fields, write one to clear bits 0 and 1
   localparam int ST_FIRST  = 0;
   localparam int ST_SECOND = 1;
   localparam int ST_LINE   = 2;

   // Counter register fields
   localparam int CNT_MODE_LSB = 16;
   localparam int CNT_MODE_MSB = 18;
   localparam int CNT_OUT_BIT  = 19;

   // Range register fields and gain codes
   localparam int RNG_TWOS = 2;
   localparam logic [1:0] GAIN_X1   = 2'h0;
   localparam logic [1:0] GAIN_X10  = 2'h1;
   localparam logic [1:0] GAIN_X100 = 2'h2;
   localparam int SAMPLE_BITS  = 12;
   localparam int SAMPLE_STEPS = 4096;

   // Timer clock derived from the system clock
   localparam int SYS_CLK_HZ   = 10_000_000;
   localparam int TIMER_CLK_HZ = 2_000_000;
   localparam logic [2:0] TIMER_DIV = 3'(SYS_CLK_HZ / TIMER_CLK_HZ);
   localparam int NUM_CNT = 3;

   // Counter operating modes
   typedef enum logic [2:0] {
      DIP_M_TC_IRQ    = 3'b000,
      DIP_M_ONESHOT   = 3'b001,
      DIP_M_RATE      = 3'b010,
      DIP_M_SQUARE    = 3'b011,
      DIP_M_SW_STROBE = 3'b100,
      DIP_M_HW_STROBE = 3'b101
   } dip_mode_e;

   // Counter sequencing states
   typedef enum logic [1:0] {
      DIP_CS_IDLE   = 2'b00,
      DIP_CS_ARMED  = 2'b01,
      DIP_CS_RUN    = 2'b10,
      DIP_CS_STROBE = 2'b11
   } dip_cstate_e;
endpackage
`default_nettype wire

// File: rtl/dip_timer_counter.sv
`timescale 1ns/100ps
`default_nettype none
module dip_timer_counter
   import dip_pkg::*;
(
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_n,
   input  wire logic        i_tick,
   input  wire logic        i_gate,
   input  wire logic        i_load,
   input  wire logic [15:0] i_count,
   input  wire logic [2:0]  i_mode,
   output logic             o_out,
   output logic [15:0]      o_value,
   output logic [2:0]       o_mode
);
   dip_mode_e   mode;
   dip_cstate_e state;
   logic [15:0] reload;
   logic        gate_q;
   dip_mode_e   next_mode_ld;
   logic [15:0] next_cnt;
   logic        next_out;
   dip_cstate_e next_state;

   // Codes 6 and 7 alias the rate and square modes
   assign next_mode_ld = (i_mode[2:1] == 2'b11) ?
                         dip_mode_e'({1'b0, i_mode[1:0]}) :
                         dip_mode_e'(i_mode);
   // Gate edges are seen only on ticks; shorter gate pulses are lost
   wire gate_rise = i_gate & ~gate_q;
   wire last      = (o_value == 16'h0001);
   wire trig_mode = (mode != DIP_M_TC_IRQ) && (mode != DIP_M_SW_STROBE);
   wire free_run  = (mode == DIP_M_ONESHOT) || (mode == DIP_M_HW_STROBE);

   // Count sequencing, a zero load counts 65536 ticks by wrapping
   always_comb begin
      next_cnt   = o_value;
      next_out   = o_out;
      next_state = state;
      if (i_load) begin
         next_cnt   = i_count;
         next_out   = (next_mode_ld != DIP_M_TC_IRQ);
         next_state = (next_mode_ld == DIP_M_ONESHOT ||
                       next_mode_ld == DIP_M_HW_STROBE) ?
                      DIP_CS_ARMED : DIP_CS_RUN;
      end else if (i_tick) begin
         if (gate_rise && trig_mode && state != DIP_CS_IDLE) begin
            next_cnt   = reload;
            next_state = DIP_CS_RUN;
            if (mode == DIP_M_ONESHOT)
               next_out = 1'b0;
         end else begin
            case (state)
               DIP_CS_RUN: begin
                  if (i_gate || free_run) begin
                     next_cnt = o_value - 16'h0001;
                     case (mode)
                        DIP_M_TC_IRQ, DIP_M_ONESHOT: begin
                           if (last) begin
                              next_out   = 1'b1;
                              next_state = DIP_CS_IDLE;
                           end
                        end
                        DIP_M_RATE: begin
                           next_out = (o_value != 16'h0002);
                           if (last)
                              next_cnt = reload;
                        end
                        DIP_M_SQUARE: begin
                           if (last)
                              next_cnt = reload;
                           next_out = (next_cnt > {1'b0, reload[15:1]});
                        end
                        DIP_M_SW_STROBE, DIP_M_HW_STROBE: begin
                           if (last) begin
                              next_out   = 1'b0;
                              next_state = DIP_CS_STROBE;
                           end
                        end
                        default: next_state = DIP_CS_IDLE;
                     endcase
                  end else if (mode == DIP_M_RATE ||
                               mode == DIP_M_SQUARE) begin
                     next_out = 1'b1; // Low gate forces output high
                  end
               end
               DIP_CS_STROBE: begin
                  next_out   = 1'b1;
                  next_state = DIP_CS_IDLE;
               end
               default: next_state = state;
            endcase
         end
      end
   end

   // State registers
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_value <= 16'h0000;
         o_out   <= 1'b0;
         state   <= DIP_CS_IDLE;
         mode    <= DIP_M_TC_IRQ;
         reload  <= 16'h0000;
         gate_q  <= 1'b0;
      end else begin
         o_value <= next_cnt;
         o_out   <= next_out;
         state   <= next_state;
         if (i_load) begin
            mode   <= next_mode_ld;
            reload <= i_count;
         end
         if (i_tick)
            gate_q <= i_gate;
      end
   end

   assign o_mode = mode;
endmodule // dip_timer_counter
`default_nettype wire

// File: rtl/dip_pacer_irq.sv
// Functional notes
// - Two interrupt requests are held pending independently at once
// - Both requests share one active-low host interrupt line
// - First request comes from end of conversion or FIFO half full
// - Second request comes only from the pacer timer output
// - Software-written source select bits choose first and second sources
// - Each source can be disabled on its own
// - Status register shows which request is pending
// - Request stays pending until software clears it; checks other first
// - Counter one output clocks counter two to form the pacer
// - Timer clock is 2 MHz, fastest pacer is one quarter of it
// - Slowest pacer is 2 MHz over both divisors at maximum
// - Pacer output drives both the interrupt and the conversion trigger
// - Timer holds three counters, each with six modes
// - Samples span 4096 codes scaled by gain 1, 10 or 100
// - End of conversion source fires when a result is in the FIFO
// - Half full source fires when the FIFO holds 512 words
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module dip_pacer_irq
   import dip_pkg::*;
(
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_n,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_adc_eoc,
   input  wire logic        i_fifo_half_full,
   input  wire logic        i_timer0_gate,
   output logic             o_timer0_out,
   output logic             o_adc_pacer_trig,
   output logic             o_first_irq_request,
   output logic             o_second_irq_request,
   output logic             o_inta_n,
   output logic [1:0]       o_gain_code,
   output logic             o_twos_comp
);
   // Register state
   logic [2:0]  src_sel;
   logic        first_pend;
   logic        second_pend;
   logic [2:0]  div_cnt;
   logic        hf_q;
   logic        c1_out_q;
   logic        c2_out_q;

   // Counter array signals
   logic [NUM_CNT-1:0] c_tick;
   logic [NUM_CNT-1:0] c_gate;
   logic [NUM_CNT-1:0] c_load;
   logic [NUM_CNT-1:0] c_out;
   logic [15:0]        c_value [NUM_CNT];
   logic [2:0]         c_mode  [NUM_CNT];

   // Word read from one counter
   function automatic logic [31:0] cnt_word(input logic        out,
                                            input logic [2:0]  mode,
                                            input logic [15:0] value);
      cnt_word = {12'h000, out, mode, value};
   endfunction

   // APB decode; zero wait states, so every access ends in one cycle
   wire access   = i_psel & i_penable;
   wire wr_en    = access & i_pwrite;
   wire hit_src  = (i_paddr == ADDR_SRC_SEL);
   wire hit_st   = (i_paddr == ADDR_STATUS);
   wire hit_c0   = (i_paddr == ADDR_CNT0);
   wire hit_c1   = (i_paddr == ADDR_CNT1);
   wire hit_c2   = (i_paddr == ADDR_CNT2);
   wire hit_rng  = (i_paddr == ADDR_RANGE);
   wire mapped   = hit_src | hit_st | hit_c0 | hit_c1 | hit_c2 | hit_rng;
   wire wr_src   = wr_en & hit_src;
   wire wr_st    = wr_en & hit_st;
   wire wr_rng   = wr_en & hit_rng;
   wire rd_setup = i_psel & ~i_penable & ~i_pwrite;

   assign o_pready  = 1'b1;
   assign o_pslverr = access & ~mapped;

   // Counter loads by register write
   assign c_load[0] = wr_en & hit_c0;
   assign c_load[1] = wr_en & hit_c1;
   assign c_load[2] = wr_en & hit_c2;

   // Source enables and selector
   wire first_en  = src_sel[SRC_FIRST_EN];
   wire second_en = src_sel[SRC_SECOND_EN];
   wire first_hf  = src_sel[SRC_FIRST_HF];

   // Timer clock enable: one tick every fifth system clock
   wire tmr_tick = (div_cnt == TIMER_DIV - 3'h1);

   // Counter one free on the timer clock; counter two on its rising output
   assign c_tick[0] = tmr_tick;
   assign c_tick[1] = tmr_tick;
   assign c_tick[2] = c_out[1] & ~c1_out_q;
   assign c_gate[0] = i_timer0_gate;
   assign c_gate[1] = 1'b1;
   assign c_gate[2] = 1'b1;

   // Event sources
   wire pacer_rise = c_out[2] & ~c2_out_q;
   wire hf_rise    = i_fifo_half_full & ~hf_q;
   wire eoc_evt    = i_adc_eoc;
   wire first_evt  = first_hf ? hf_rise : eoc_evt;

   // Pending flags: a new event wins over a clear in the same cycle
   wire clr_first  = wr_st & i_pwdata[ST_FIRST];
   wire clr_second = wr_st & i_pwdata[ST_SECOND];
   wire next_first_pend  = (first_en & first_evt) |
                           (first_pend & ~clr_first);
   wire next_second_pend = (second_en & pacer_rise) |
                           (second_pend & ~clr_second);

   // Shared line, a disabled source cannot hold it
   wire first_act  = first_pend & first_en;
   wire second_act = second_pend & second_en;
   wire line_act   = first_act | second_act;
   wire next_line  = (next_first_pend & first_en) |
                     (next_second_pend & second_en);

   // Read data selection
   wire [31:0] st_word = {29'h0, line_act, second_pend, first_pend};
   wire [31:0] rd_mux  =
      hit_src ? {29'h0, src_sel} :
      hit_st  ? st_word :
      hit_c0  ? cnt_word(c_out[0], c_mode[0], c_value[0]) :
      hit_c1  ? cnt_word(c_out[1], c_mode[1], c_value[1]) :
      hit_c2  ? cnt_word(c_out[2], c_mode[2], c_value[2]) :
      hit_rng ? {29'h0, o_twos_comp, o_gain_code} :
      32'h0000_0000;

   // Gain code 3 has no meaning, so such a write keeps the old gain
   wire gain_ok = (i_pwdata[1:0] != 2'h3);

   // Three counters, six modes each
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CNT; gi = gi + 1) begin : g_cnt
         dip_timer_counter u_cnt (
            .i_clk_sys (i_clk_sys),
            .i_rst_n   (i_rst_n),
            .i_tick    (c_tick[gi]),
            .i_gate    (c_gate[gi]),
            .i_load    (c_load[gi]),
            .i_count   (i_pwdata[15:0]),
            .i_mode    (i_pwdata[CNT_MODE_MSB:CNT_MODE_LSB]),
            .o_out     (c_out[gi]),
            .o_value   (c_value[gi]),
            .o_mode    (c_mode[gi])
         );
      end
   endgenerate

   // Timer clock divider
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n)
         div_cnt <= 3'h0;
      else if (tmr_tick)
         div_cnt <= 3'h0;
      else
         div_cnt <= div_cnt + 3'h1;
   end

   // Edge detectors for counter one and two outputs and half-full flag
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         c1_out_q <= 1'b0;
         c2_out_q <= 1'b0;
         hf_q     <= 1'b0;
      end else begin
         c1_out_q <= c_out[1];
         c2_out_q <= c_out[2];
         hf_q     <= i_fifo_half_full;
      end
   end

   // Source select register, both sources off after reset
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n)
         src_sel <= SRC_SEL_RST;
      else if (wr_src)
         src_sel <= i_pwdata[2:0];
   end

   // Pending requests
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         first_pend  <= 1'b0;
         second_pend <= 1'b0;
      end else begin
         first_pend  <= next_first_pend;
         second_pend <= next_second_pend;
      end
   end

   // Registered request outputs and host line
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_first_irq_request  <= 1'b0;
         o_second_irq_request <= 1'b0;
         o_inta_n             <= 1'b1;
      end else begin
         o_first_irq_request  <= next_first_pend & first_en;
         o_second_irq_request <= next_second_pend & second_en;
         o_inta_n             <= ~next_line;
      end
   end

   // Pacer conversion trigger and free counter output
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_adc_pacer_trig <= 1'b0;
         o_timer0_out     <= 1'b0;
      end else begin
         o_adc_pacer_trig <= pacer_rise;
         o_timer0_out     <= c_out[0];
      end
   end

   // Range register: gain code and sample coding
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_gain_code <= GAIN_X1;
         o_twos_comp <= 1'b0;
      end else if (wr_rng) begin
         if (gain_ok)
            o_gain_code <= i_pwdata[1:0];
         o_twos_comp <= i_pwdata[RNG_TWOS];
      end
   end

   // Read data captured in the setup cycle, stable through access
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n)
         o_prdata <= 32'h0000_0000;
      else if (rd_setup)
         o_prdata <= rd_mux;
   end
endmodule // dip_pacer_irq
`default_nettype wire

// File: verif/dip_pacer_irq_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module dip_pacer_irq_assertions
   import dip_pkg::*;
(
   input wire logic        i_clk_sys,
   input wire logic        i_rst_n,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [7:0]  i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        i_adc_eoc,
   input wire logic        i_fifo_half_full,
   input wire logic        i_timer0_gate,
   input wire logic        o_timer0_out,
   input wire logic        o_adc_pacer_trig,
   input wire logic        o_first_irq_request,
   input wire logic        o_second_irq_request,
   input wire logic        o_inta_n,
   input wire logic [1:0]  o_gain_code,
   input wire logic        o_twos_comp
);
   // Completed APB writes to the two irq registers
   wire logic wr     = i_psel & i_penable & i_pwrite;
   wire logic wr_st  = wr & (i_paddr == ADDR_STATUS);
   wire logic wr_sel = wr & (i_paddr == ADDR_SRC_SEL);

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   // Shared host line mirrors the OR of the masked requests
   AST_LINE: assert property (
      o_inta_n == !(o_first_irq_request | o_second_irq_request))
      else $error("host line disagrees with requests");
   // Nothing pending and no trigger right after reset
   AST_RESET_IDLE: assert property (
      !$past(i_rst_n) |-> o_inta_n && !o_first_irq_request
         && !o_second_irq_request && !o_adc_pacer_trig)
      else $error("outputs not idle after reset");
   // Trigger is a single-cycle pulse
   AST_TRIG_PULSE: assert property (
      o_adc_pacer_trig |=> !o_adc_pacer_trig)
      else $error("pacer trigger longer than one cycle");
   // First request rises only after an event or a select write
   AST_FIRST_SRC: assert property (
      $rose(o_first_irq_request)
         |-> $past(i_adc_eoc | i_fifo_half_full) || $past(wr_sel, 2))
      else $error("first request without a cause");
   // Pending set and trigger both come from one counter edge; an enable
   // write shows a raw pending bit two samples later
   AST_SECOND_SRC: assert property (
      $rose(o_second_irq_request) && !$past(wr_sel, 2)
         |-> $past(o_adc_pacer_trig) or ##[0:2] o_adc_pacer_trig)
      else $error("second request without a pacer edge");
   // A request only falls through a clear or a select write
   AST_HOLD_FIRST: assert property (
      $fell(o_first_irq_request)
         |-> $past(wr_st && i_pwdata[ST_FIRST]) || $past(wr_sel, 2))
      else $error("first request dropped without software");
   // Event in the clear cycle wins, so only quiet cycles are checked
   AST_CLEAR_FIRST: assert property (
      wr_st && i_pwdata[ST_FIRST] && !i_adc_eoc && !i_fifo_half_full
         |=> !o_first_irq_request)
      else $error("first request survived its clear");
   // Clearing only the first leaves the second one standing
   AST_KEEP_SECOND: assert property (
      o_second_irq_request && wr_st && !i_pwdata[ST_SECOND]
         |=> o_second_irq_request)
      else $error("second request lost on a foreign clear");

   // Main scenarios
   COV_BOTH: cover property (o_first_irq_request && o_second_irq_request);
   COV_TRIG: cover property (o_adc_pacer_trig);
   COV_UNMAPPED: cover property (o_pslverr);
endmodule // dip_pacer_irq_assertions

bind dip_pacer_irq dip_pacer_irq_assertions u_chk (.i_clk_sys, .i_rst_n,
   .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
   .o_pready, .o_pslverr, .i_adc_eoc, .i_fifo_half_full, .i_timer0_gate,
   .o_timer0_out, .o_adc_pacer_trig, .o_first_irq_request,
   .o_second_irq_request, .o_inta_n, .o_gain_code, .o_twos_comp);
`default_nettype wire

// File: verif/dip_adc_model.sv
`timescale 1ns/100ps
`default_nettype none
module dip_adc_model #(
   parameter int LAT        = 3,
   parameter int HALF_WORDS = 512
) (
   input  wire logic i_clk_sys,
   input  wire logic i_rst_n,
   input  wire logic i_start,
   input  wire logic i_drain,
   output logic      o_eoc,
   output logic      o_half_full
);
   logic [7:0] conv_pipe;
   int         words;

   // Each start finishes LAT cycles later; the word lands in the FIFO then
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         conv_pipe <= 8'h00;
         words     <= 0;
      end else begin
         conv_pipe <= {conv_pipe[6:0], i_start};
         if (i_drain) begin
            words <= 0;
         end else if (o_eoc) begin
            words <= words + 1;
         end
      end
   end
   assign o_eoc       = conv_pipe[LAT-1];
   // Level flag; the reader empties a whole block at once
   assign o_half_full = (words >= HALF_WORDS);
endmodule // dip_adc_model
`default_nettype wire

// File: verif/dip_pacer_irq_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
   n_checks++; \
   if ((got) !== (exp)) begin \
      n_fail++; \
      $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
   end \
end
module dip_pacer_irq_test
   import dip_pkg::*;
;
   localparam int HALF = 4;
   localparam int LIM  = 2000;
   logic        i_clk_sys, i_rst_n, i_psel, i_penable, i_pwrite;
   logic [7:0]  i_paddr;
   logic [31:0] i_pwdata, o_prdata, rd;
   logic        o_pready, o_pslverr, i_adc_eoc, i_fifo_half_full;
   logic        i_timer0_gate, o_timer0_out, o_adc_pacer_trig, o_inta_n;
   logic        o_first_irq_request, o_second_irq_request, o_twos_comp;
   logic        er, go, drain;
   logic [1:0]  o_gain_code;
   logic [6:0]  rows [6];
   int          n_fail = 0;
   int          n_checks = 0;
   int          cyc;

   dip_pacer_irq dut (.i_clk_sys, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
      .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_adc_eoc,
      .i_fifo_half_full, .i_timer0_gate, .o_timer0_out, .o_adc_pacer_trig,
      .o_first_irq_request, .o_second_irq_request, .o_inta_n, .o_gain_code,
      .o_twos_comp);
   // Converter behind the FIFO, started by the pacer or by the bench
   dip_adc_model #(.LAT(3), .HALF_WORDS(HALF)) u_adc (.i_clk_sys, .i_rst_n,
      .i_start(go | o_adc_pacer_trig), .i_drain(drain), .o_eoc(i_adc_eoc),
      .o_half_full(i_fifo_half_full));

   initial begin
      i_clk_sys = 1'b0;
      forever #50 i_clk_sys = ~i_clk_sys;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk_sys);
      i_psel   <= 1'b1;
      i_pwrite <= w;
      i_paddr  <= a;
      i_pwdata <= d;
      @(posedge i_clk_sys);
      i_penable <= 1'b1;
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (o_pready !== 1'b1 && n < LIM);
      rd = o_prdata;
      er = o_pslverr;
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
      if (n >= LIM) begin
         n_fail++;
         complete_run();
      end
   endtask

   // Bounded wait for the trigger (s=0) or the second request (s=1)
   task automatic wait_hi(input int s);
      cyc = 0;
      do begin
         @(posedge i_clk_sys);
         cyc++;
      end while ((s == 0 ? o_adc_pacer_trig : o_second_irq_request) !== 1'b1
                 && cyc < LIM);
      if (cyc >= LIM) begin
         n_fail++;
         complete_run();
      end
   endtask

   initial begin
      // Rows: {select[2:0], fill FIFO to half-full, expected status[2:0]}
      rows = '{7'h15, 7'h1d, 7'h5d, 7'h50, 7'h08, 7'h20};
      {i_psel, i_penable, i_pwrite, go, drain} = 5'h00;
      i_paddr = 8'h00;
      i_pwdata = 32'h0;
      i_timer0_gate = 1'b1;
      i_rst_n = 1'b0;
      repeat (8) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      apb(1'b0, ADDR_SRC_SEL, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b0, ADDR_RANGE, 32'h0);
      `CHK(rd, 32'h0)
      $display("reset test done");
      foreach (rows[i]) begin
         apb(1'b1, ADDR_SRC_SEL, {29'h0, rows[i][6:4]});
         repeat (rows[i][3] ? HALF : 1) begin
            @(posedge i_clk_sys);
            go <= 1'b1;
            @(posedge i_clk_sys);
            go <= 1'b0;
         end
         repeat (6) @(posedge i_clk_sys);
         apb(1'b0, ADDR_STATUS, 32'h0);
         `CHK(rd[2:0], rows[i][2:0])
         `CHK(o_inta_n, ~rows[i][0])
         apb(1'b1, ADDR_STATUS, 32'h3);
         @(posedge i_clk_sys);
         drain <= 1'b1;
         @(posedge i_clk_sys);
         drain <= 1'b0;
      end
      $display("source table done");
      // Gain code 3 is refused, the coding bit still moves
      apb(1'b1, ADDR_RANGE, 32'h6);
      @(negedge i_clk_sys);
      `CHK({o_gain_code, o_twos_comp}, 3'h5)
      apb(1'b1, ADDR_RANGE, 32'h3);
      @(negedge i_clk_sys);
      `CHK({o_gain_code, o_twos_comp}, 3'h4)
      for (int m = 0; m < 6; m++) begin
         apb(1'b1, ADDR_CNT0, {13'h0, 3'(m), 16'h0010});
         apb(1'b0, ADDR_CNT0, 32'h0);
         `CHK(rd[18:16], 3'(m))
         // Only mode 0 starts with its output low after a load
         `CHK(rd[19], m != 0)
         `CHK(o_timer0_out, m != 0)
      end
      // Unmapped write must not disturb the select register
      apb(1'b1, 8'h18, 32'hffff_ffff);
      `CHK(er, 1'b1)
      apb(1'b0, ADDR_SRC_SEL, 32'h0);
      `CHK(rd, 32'h2)
      $display("register tests done");
      // Pacer at 100 kHz keeps the converter within its rate
      apb(1'b1, ADDR_SRC_SEL, 32'h3);
      apb(1'b1, ADDR_CNT1, {13'h0, DIP_M_RATE, 16'h0005});
      apb(1'b1, ADDR_CNT2, {13'h0, DIP_M_SQUARE, 16'h0004});
      // The load itself raises counter two; a short period follows, then the steady one
      wait_hi(0);
      wait_hi(0);
      wait_hi(0);
      `CHK(cyc, 5 * 4 * (SYS_CLK_HZ / TIMER_CLK_HZ))
      wait_hi(1);
      repeat (8) @(posedge i_clk_sys);
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rd[2:0], 3'h7)
      apb(1'b1, ADDR_STATUS, 32'h1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rd[1:0], 2'h2)
      apb(1'b1, ADDR_SRC_SEL, 32'h1);
      // Outputs use the new enable one edge after the write
      @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      `CHK({o_second_irq_request, o_inta_n}, 2'h1)
      $display("pacer test done");
      // Reset in mid-run with a request pending
      wait_hi(0);
      repeat (8) @(posedge i_clk_sys);
      `CHK({o_first_irq_request, o_inta_n}, 2'h2)
      i_rst_n <= 1'b0;
      @(negedge i_clk_sys);
      `CHK({o_first_irq_request, o_inta_n, o_adc_pacer_trig}, 3'h2)
      @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      apb(1'b0, ADDR_SRC_SEL, 32'h0);
      `CHK(rd, 32'h0)
      $display("mid-run reset test done");
      complete_run();
   end
endmodule // dip_pacer_irq_test
`default_nettype wire
